// ### hw/sas_pkg.sv
// sas_pkg: shared constants for the converter scan sequencer
// assumes a 10 MHz system clock and an APB master with 32-bit data
package sas_pkg;
  localparam int RES_W = 12;           // result width
  localparam int NCH = 8;              // channels per converter
  localparam int CONV_MIN_CLK = 18;    // least converter clocks per conversion
  localparam int CLK_HZ = 10000000;
  localparam int MAX_CONV_HZ = 36000000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHEN = 8'h04;
  localparam logic [7:0] OFS_CHDIFF = 8'h08;
  localparam logic [7:0] OFS_SAMPLE = 8'h0C;
  localparam logic [7:0] OFS_LIMLO = 8'h10;
  localparam logic [7:0] OFS_LIMHI = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_FIFO = 8'h1C;
  localparam logic [7:0] OFS_RES0 = 8'h20;
  // ctrl fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_CONT = 1;
  localparam int CTRL_REF_LO = 2;      // two bits: reference select
  localparam int CTRL_LPCLK = 4;       // deep sleep clock: 0 2 MHz, 1 8 MHz
  localparam int CTRL_TEMP_EN = 5;
  localparam int CTRL_MUXBUS = 6;
  localparam int CTRL_LIM_BELOW = 7;
  localparam int CTRL_LIM_ABOVE = 8;
  localparam int CTRL_TEMP_CH_LO = 9;  // three bits: channel replaced by temp sensor
  // status bits; done and range are write one to clear, busy is read only
  localparam int ST_DONE = 0;
  localparam int ST_RANGE = 1;
  localparam int ST_BUSY = 2;
  typedef enum logic [1:0] {SAS_REF_VDDA, SAS_REF_HALF, SAS_REF_BANDGAP, SAS_REF_EXT} sas_ref_t;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam logic [15:0] SAMPLE_RST = 16'h0004;
endpackage

// ### hw/sas_fifo.sv
// sas_fifo: small valid/ready FIFO for conversion results
// assumes one clock and an asynchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module sas_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic         clk,     // clock
  input  wire logic         reset,   // async reset
  input  wire logic [W-1:0] in_data, // write data
  input  wire logic         in_valid,// write request
  output logic              in_ready,// space left
  output logic [W-1:0]      out_data,// head word
  output logic              out_valid,// not empty
  input  wire logic         out_ready // reader takes
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("depth must be a power of two");
  end
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg, rp_reg;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  // honest full/empty from pointer wrap bit
  assign in_ready  = !((wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
  assign out_valid = wp_reg != rp_reg;
  assign out_data  = mem[rp_reg[AW-1:0]];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
    end
  end
  // storage has no reset, only written on push
  always_ff @(posedge clk) begin
    if (push) mem[wp_reg[AW-1:0]] <= in_data;
  end
endmodule // sas_fifo
`default_nettype wire

// ### hw/sas_top.sv
// sas_top: scan sequencer and conversion timing for a 12-bit SAR converter
// assumes an APB master, an analog front end answering with a result and done pulse
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sas_top
  import sas_pkg::*;
#(
  parameter int FIFO_D = 4
) (
  input  wire logic              clk,          // 10 MHz clock
  input  wire logic              reset,        // async reset, active high
  input  wire logic [7:0]        paddr,        // apb address
  input  wire logic              psel,         // apb select
  input  wire logic              penable,      // apb enable
  input  wire logic              pwrite,       // apb direction
  input  wire logic [31:0]       pwdata,       // apb write data
  output logic [31:0]            prdata,       // apb read data
  output logic                   pready,       // apb ready
  output logic                   pslverr,      // apb error
  input  wire logic              deep_sleep,   // system deep sleep level
  input  wire logic              hibernate,    // system hibernate level
  input  wire logic              sync_in,      // shared sampling instant, from pin
  output logic                   sync_out,     // our sampling instant to the peer
  output logic                   irq,          // combined interrupt
  output logic                   fe_sample,    // front end tracking input
  output logic                   fe_convert,   // front end start conversion pulse
  output logic [2:0]             fe_chan,      // selected input channel
  output logic                   fe_diff,      // differential input
  output logic [1:0]             fe_ref,       // reference select
  output logic                   fe_temp_en,   // temperature diode bias
  output logic                   fe_temp_sel,  // temperature diode on the input
  output logic                   fe_mux_bus,   // shared_analog_mux_bus on the input
  output logic                   fe_lp_clk_sel,// low_power_oscillator 8 MHz when high
  output logic                   fe_lp_mode,   // run from low_power_oscillator
  input  wire logic [RES_W-1:0]  fe_result,    // conversion result
  input  wire logic              fe_done       // result valid pulse
);
  // refuse settings the logic cannot serve, before anything runs
  if (FIFO_D < 2) begin : g_bad_fifo
    $error("fifo depth too small");
  end
  // converter clock ratio; the extra cycle covers what integer division drops
  localparam int CONV_CYC = CONV_MIN_CLK * CLK_HZ / MAX_CONV_HZ + 1;
  if (CLK_HZ > MAX_CONV_HZ) begin : g_bad_clk
    $error("clock above converter limit");
  end
  // channel numbers are three bits wide and the spacing count eight
  if (NCH != 8 || CONV_CYC > 255) begin : g_bad_width
    $error("channel count or conversion spacing out of range");
  end

  typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_CONV} sas_state_t;
  sas_state_t st_reg;
  logic [31:0] ctrl_reg;
  logic [NCH-1:0] chen_reg, chdiff_reg;
  logic [15:0] samp_reg, cnt_reg;
  logic [RES_W-1:0] limlo_reg, limhi_reg;
  logic [RES_W-1:0] res_reg [NCH];
  logic [2:0] ch_reg, conv_ch_reg;
  logic [NCH-1:0] seen_reg;
  logic done_reg, range_reg, pready_reg, stall_reg;
  logic [31:0] prdata_reg;
  logic [2:0] sync_ff;
  logic sync_reg, sync_out_reg, conv_pulse_reg;
  logic [7:0] ccnt_reg;

  // sync input: three stages, change counts once the last two agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) sync_ff <= '0;
    else sync_ff <= {sync_ff[1:0], sync_in};
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) sync_reg <= 1'b0;
    else if (sync_ff[2] == sync_ff[1]) sync_reg <= sync_ff[2];
  end
  // one cycle pulse: sync_reg only follows once the last two stages agree
  wire sync_rise = sync_ff[1] && sync_ff[2] && !sync_reg;

  // control decode
  wire en        = ctrl_reg[CTRL_EN] && !hibernate;
  wire sync_mode = ctrl_reg[CTRL_CONT] == 1'b0;
  wire [2:0] temp_ch = ctrl_reg[CTRL_TEMP_CH_LO +: 3];
  wire temp_on   = ctrl_reg[CTRL_TEMP_EN];
  // next enabled channel after the current one, wrapping round
  logic [2:0] nxt_ch;
  always_comb begin
    nxt_ch = ch_reg;
    for (int i = NCH - 1; i >= 1; i--) begin
      if (chen_reg[3'(ch_reg + 3'(i))]) begin
        nxt_ch = 3'(ch_reg + 3'(i));
      end
    end
  end
  logic [2:0] first_ch;
  always_comb begin
    first_ch = '0;
    for (int i = NCH - 1; i >= 0; i--) if (chen_reg[i]) first_ch = 3'(i);
  end

  // result path through the fifo; stalls the sequencer when full
  logic fifo_in_ready, fifo_out_valid;
  logic [15:0] fifo_out_data;
  // pop when the read completes; the head was latched into prdata a cycle before
  wire fifo_pop = psel && penable && !pwrite && pready_reg && paddr == OFS_FIFO;
  sas_fifo #(.W(16), .D(FIFO_D)) u_fifo (
    .clk      (clk),
    .reset    (reset),
    .in_data  ({1'b0, conv_ch_reg, fe_result}),
    .in_valid (fe_done && st_reg != SAS_IDLE),
    .in_ready (fifo_in_ready),
    .out_data (fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  // limit comparison on each result as it lands
  wire below = ctrl_reg[CTRL_LIM_BELOW] && fe_result < limlo_reg;
  wire above = ctrl_reg[CTRL_LIM_ABOVE] && fe_result > limhi_reg;
  wire res_in = fe_done && st_reg != SAS_IDLE;
  wire range_hit = res_in && (below || above);
  wire scan_end = res_in && ((seen_reg | (NCH'(1) << conv_ch_reg)) & chen_reg) == chen_reg;

  // apb access
  wire acc = psel && penable && pready_reg;
  wire wr = acc && pwrite;
  wire wr_status = wr && paddr == OFS_STATUS;
  wire start_ok = en && |chen_reg && fifo_in_ready && (!sync_mode || sync_rise);

  // sequencer: sample window, then conversion of ch while next channel samples
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= SAS_IDLE;
      cnt_reg <= '0;
      ch_reg <= '0;
      conv_ch_reg <= '0;
      conv_pulse_reg <= 1'b0;
      ccnt_reg <= '0;
    end else begin
      conv_pulse_reg <= 1'b0;
      case (st_reg)
        SAS_IDLE: begin
          if (start_ok) begin
            st_reg <= SAS_SAMPLE;
            ch_reg <= first_ch;
            cnt_reg <= samp_reg;
          end
        end
        SAS_SAMPLE: begin
          // spacing count runs here too, or a quick front end would leave it
          // stuck above zero and stall the scan for good
          if (ccnt_reg != 0) ccnt_reg <= ccnt_reg - 8'd1;
          if (!en) st_reg <= SAS_IDLE;
          else if (cnt_reg != 0) cnt_reg <= cnt_reg - 16'd1;
          else if (ccnt_reg == 0 && fifo_in_ready) begin
            st_reg <= SAS_CONV;
            conv_ch_reg <= ch_reg;
            conv_pulse_reg <= 1'b1;
            ccnt_reg <= 8'(CONV_CYC);
            ch_reg <= nxt_ch;
            cnt_reg <= samp_reg;
          end
        end
        SAS_CONV: begin
          // next channel samples during this conversion: no gap
          if (cnt_reg != 0) cnt_reg <= cnt_reg - 16'd1;
          if (ccnt_reg != 0) ccnt_reg <= ccnt_reg - 8'd1;
          if (!en) st_reg <= SAS_IDLE;
          else if (res_in) begin
            if (scan_end && !ctrl_reg[CTRL_CONT] && !sync_mode) st_reg <= SAS_IDLE;
            else if (scan_end && sync_mode) st_reg <= SAS_IDLE;
            else st_reg <= SAS_SAMPLE;
          end
        end
        default: st_reg <= SAS_IDLE;
      endcase
    end
  end

  // per channel results and scan coverage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seen_reg <= '0;
      for (int i = 0; i < NCH; i++) res_reg[i] <= '0;
    end else if (res_in) begin
      res_reg[conv_ch_reg] <= fe_result;
      seen_reg <= scan_end ? '0 : seen_reg | (NCH'(1) << conv_ch_reg);
    end else if (st_reg == SAS_IDLE) begin
      seen_reg <= '0;
    end
  end

  // status flags: hardware set wins over write-one-to-clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_reg <= 1'b0;
      range_reg <= 1'b0;
    end else begin
      done_reg <= scan_end || (done_reg && !(wr_status && pwdata[ST_DONE]));
      range_reg <= range_hit || (range_reg && !(wr_status && pwdata[ST_RANGE]));
    end
  end

  // register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RST;
      chen_reg <= '0;
      chdiff_reg <= '0;
      samp_reg <= SAMPLE_RST;
      limlo_reg <= '0;
      limhi_reg <= '1;
    end else if (wr) begin
      if (paddr == OFS_CTRL) ctrl_reg <= pwdata;
      else if (paddr == OFS_CHEN) chen_reg <= pwdata[NCH-1:0];
      else if (paddr == OFS_CHDIFF) chdiff_reg <= pwdata[NCH-1:0];
      else if (paddr == OFS_SAMPLE) samp_reg <= pwdata[15:0];
      else if (paddr == OFS_LIMLO) limlo_reg <= pwdata[RES_W-1:0];
      else if (paddr == OFS_LIMHI) limhi_reg <= pwdata[RES_W-1:0];
    end
  end

  // read mux and decode of unmapped addresses
  wire is_res = paddr >= OFS_RES0 && paddr < OFS_RES0 + 8'(4 * NCH) && paddr[1:0] == 2'b00;
  wire [2:0] res_idx = 3'(paddr[7:2] - OFS_RES0[7:2]);
  wire mapped = paddr <= OFS_FIFO && paddr[1:0] == 2'b00 || is_res;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (paddr == OFS_CTRL) rd_mux = ctrl_reg;
    else if (paddr == OFS_CHEN) rd_mux = 32'(chen_reg);
    else if (paddr == OFS_CHDIFF) rd_mux = 32'(chdiff_reg);
    else if (paddr == OFS_SAMPLE) rd_mux = 32'(samp_reg);
    else if (paddr == OFS_LIMLO) rd_mux = 32'(limlo_reg);
    else if (paddr == OFS_LIMHI) rd_mux = 32'(limhi_reg);
    else if (paddr == OFS_STATUS) rd_mux = {29'h0, st_reg != SAS_IDLE, range_reg, done_reg};
    else if (paddr == OFS_FIFO) rd_mux = {fifo_out_valid, 15'h0, fifo_out_data};
    else if (is_res) rd_mux = 32'(res_reg[res_idx]);
  end

  // one wait state: ready in the second access cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      stall_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      prdata_reg <= (psel && penable && !pready_reg && !pwrite) ? rd_mux : prdata_reg;
      stall_reg <= psel && penable && !pready_reg && !mapped;
    end
  end
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  // error flag is its own flop, raised only alongside ready
  assign pslverr = stall_reg;

  // front end drive, all registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fe_sample <= 1'b0;
      fe_chan <= '0;
      fe_diff <= 1'b0;
      fe_ref <= SAS_REF_VDDA;
      fe_temp_en <= 1'b0;
      fe_temp_sel <= 1'b0;
      fe_mux_bus <= 1'b0;
      fe_lp_clk_sel <= 1'b0;
      fe_lp_mode <= 1'b0;
      sync_out_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      fe_sample <= en && st_reg != SAS_IDLE;
      fe_chan <= ch_reg;
      fe_diff <= chdiff_reg[ch_reg];
      fe_ref <= ctrl_reg[CTRL_REF_LO +: 2];
      fe_temp_en <= temp_on;
      fe_temp_sel <= temp_on && chen_reg[temp_ch] && ch_reg == temp_ch;
      fe_mux_bus <= ctrl_reg[CTRL_MUXBUS];
      fe_lp_clk_sel <= ctrl_reg[CTRL_LPCLK];
      fe_lp_mode <= deep_sleep && en;
      sync_out_reg <= start_ok && st_reg == SAS_IDLE;
      irq <= done_reg || range_reg;
    end
  end
  assign fe_convert = conv_pulse_reg;
  assign sync_out = sync_out_reg;
endmodule // sas_top
`default_nettype wire

// ### test/sas_checker.sv
// sas_checker: port-level checks on the scan sequencer
// assumes binding into sas_top, one clock, async active high reset
`timescale 1ns/1ps
`default_nettype none
module sas_checker (
  input wire logic        clk,        // clock
  input wire logic        reset,      // async reset
  input wire logic [7:0]  paddr,      // apb address
  input wire logic        psel,       // apb select
  input wire logic        penable,    // apb enable
  input wire logic        pwrite,     // apb direction
  input wire logic [31:0] prdata,     // apb read data
  input wire logic        pready,     // apb ready
  input wire logic        pslverr,    // apb error
  input wire logic        hibernate,  // hibernate level
  input wire logic        sync_out,   // scan start pulse
  input wire logic        fe_sample,  // tracking level
  input wire logic        fe_convert  // convert pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // decode of holes: past the last result slot or not word aligned
  wire unmapped = (paddr > 8'h3C) || (paddr[1:0] != 2'h0);
  wire access   = psel && penable;
  a_apb_one_wait: assert property ($rose(access) |=> pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stands too long");
  a_err_decode: assert property (pready |-> pslverr == unmapped)
    else $error("error flag disagrees with address");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(access && !pwrite))
    else $error("read data moved without a read");
  a_conv_spacing: assert property (fe_convert |=> !fe_convert [*5])
    else $error("conversions closer than six cycles");
  a_sample_first: assert property (fe_convert |-> $past(fe_sample))
    else $error("convert without a sample window");
  a_hib_idle: assert property (hibernate && $past(hibernate) |-> !fe_convert)
    else $error("conversion during hibernate");
  a_hib_no_start: assert property (hibernate && $past(hibernate) |-> !sync_out)
    else $error("scan start during hibernate");
  a_sync_pulse: assert property (sync_out |=> !sync_out)
    else $error("scan start pulse too long");
  c_convert: cover property (fe_convert);
  c_refused: cover property (pready && pslverr);
  c_scan: cover property (sync_out ##[1:100] fe_convert);
endmodule // sas_checker
bind sas_top sas_checker sas_checker_i (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hibernate(hibernate), .sync_out(sync_out), .fe_sample(fe_sample), .fe_convert(fe_convert));
`default_nettype wire

// ### test/sas_fe_model.sv
// sas_fe_model: behavioural sample-and-hold and converter front end
// assumes one clock; result value is supplied by the bench
`timescale 1ns/1ps
`default_nettype none
module sas_fe_model (
  input wire logic        clk,        // clock
  input wire logic        reset,      // async reset
  input wire logic        fe_convert, // start pulse
  input wire logic        slow,       // long conversion when high
  input wire logic [11:0] next_res,   // value of the next result
  output logic [11:0]     fe_result,  // result, scrambled outside done
  output logic            fe_done     // result valid pulse
);
  int cnt;
  // count conversion time, then hand the 12-bit result for one cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      fe_done <= 1'b0;
      fe_result <= 12'h000;
    end else begin
      fe_done <= 1'b0;
      fe_result <= ~fe_result; // stale value never looks steady
      if (fe_convert) cnt <= slow ? 12 : 5;
      else if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1) begin
        fe_done <= 1'b1;
        fe_result <= next_res;
      end
    end
  end
endmodule // sas_fe_model
`default_nettype wire

// ### test/sar_adc_scan_sequencer_tb_top.sv
// sar_adc_scan_sequencer_tb_top: self-checking bench for sas_top
// assumes sas_fe_model on the front end and the checker bound in
`timescale 1ns/1ps
`default_nettype none
module sar_adc_scan_sequencer_tb_top;
  import sas_pkg::*;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic deep_sleep = 1'b0, hibernate = 1'b0, sync_in = 1'b0, slow = 1'b0, temp_on = 1'b0;
  logic [7:0]  paddr = 8'h00, chen = 8'h00, diff = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'hA3BC;
  logic [11:0] fe_result, next_res = 12'h001, mres[8];
  logic [2:0]  fe_chan, prev = 3'h7, cur = 3'h0, tch = 3'h0;
  logic [1:0]  fe_ref;
  logic pready, pslverr, sync_out, irq, fe_sample, fe_convert, fe_diff, fe_temp_en;
  logic fe_temp_sel, fe_mux_bus, fe_lp_clk_sel, fe_lp_mode, fe_done;
  logic [15:0] mq[$];
  int error_cnt = 0, total_checks = 0, cyc = 0, nconv = 0, n;
  sas_top #(.FIFO_D(4)) sas_top_i (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .deep_sleep(deep_sleep), .hibernate(hibernate), .sync_in(sync_in),
    .sync_out(sync_out), .irq(irq), .fe_sample(fe_sample), .fe_convert(fe_convert),
    .fe_chan(fe_chan), .fe_diff(fe_diff), .fe_ref(fe_ref), .fe_temp_en(fe_temp_en),
    .fe_temp_sel(fe_temp_sel), .fe_mux_bus(fe_mux_bus), .fe_lp_clk_sel(fe_lp_clk_sel),
    .fe_lp_mode(fe_lp_mode), .fe_result(fe_result), .fe_done(fe_done));
  sas_fe_model sas_fe_model_i (.clk(clk), .reset(reset), .fe_convert(fe_convert),
    .slow(slow), .next_res(next_res), .fe_result(fe_result), .fe_done(fe_done));
  always #50 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [2:0] next_en(input logic [2:0] p, input logic [7:0] m);
    logic [2:0] c;
    c = p;
    repeat (8) begin
      c = c + 3'h1;
      if (m[c]) return c;
    end
    return p;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ch(input logic [2:0] got, input logic [2:0] exp);
    chk({29'h0, got}, {29'h0, exp});
  endtask
  // one apb transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // drain the fifo against the model queue, then expect it empty
  task automatic fifo_drain(input int k);
    repeat (k) begin
      apb(1'b0, OFS_FIFO, 32'h0);
      chk(rd, {16'h8000, mq.pop_front()});
    end
    apb(1'b0, OFS_FIFO, 32'h0);
    chk(rd[31], 1'b0);
    mq.delete();
  endtask
  task automatic scan_sync;
    nconv = 0;
    @(posedge clk) sync_in <= 1'b1;
    repeat (4) @(posedge clk);
    sync_in <= 1'b0;
  endtask
  task automatic wait_done;
    n = 0;
    do begin apb(1'b0, OFS_STATUS, 32'h0); n++; end while (rd[ST_DONE] !== 1'b1 && n < 100);
    chk(rd[ST_DONE], 1'b1);
    chk(nconv, $countones(chen));
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      summarize();
    end
  end
  // behavioural model: channel order, per-channel results and fifo words
  always @(posedge clk) if (!reset) begin
    if (sync_out === 1'b1) prev = 3'h7;
    if (fe_convert === 1'b1) begin
      cur = next_en(prev, chen);
      chk_ch(fe_chan, cur);
      chk(fe_diff, diff[cur]);
      chk(fe_temp_sel, temp_on && cur == tch);
      prev = cur;
      nconv++;
    end
    if (fe_done === 1'b1) begin
      mres[cur] = fe_result;
      mq.push_back({1'b0, cur, fe_result});
      lfsr = nxt(lfsr);
      next_res <= {1'b0, lfsr[10:1], 1'b1}; // never zero, never full scale
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // reset values, then two holes in the map
    foreach (mres[i]) if (i < 6) begin
      apb(1'b0, 8'(i * 4 + (i == 5 ? 4 : 0)), 32'h0);
      chk(rd, i == 3 ? 32'(SAMPLE_RST) : 32'h0);
    end
    apb(1'b0, OFS_LIMHI, 32'h0);
    chk(rd, 32'hFFF);
    apb(1'b1, 8'h40, 32'h5);
    chk(err, 1'b1);
    apb(1'b0, 8'h42, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // every reference choice and the routing levels
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFS_CTRL, 32'h71 | (k << 2));
      repeat (2) @(posedge clk); // output flop follows the register a cycle later
      chk(fe_ref, k);
    end
    chk({fe_temp_en, fe_mux_bus, fe_lp_clk_sel}, 3'h7);
    deep_sleep <= 1'b1;
    repeat (3) @(posedge clk);
    chk(fe_lp_mode, 1'b1);
    deep_sleep <= 1'b0;
    repeat (3) @(posedge clk);
    chk(fe_lp_mode, 1'b0);
    // synchronised single scans over random channel sets
    for (int s = 0; s < 4; s++) begin
      lfsr = nxt(lfsr);
      chen = lfsr[7:0] & 8'h3C;
      if (chen == 8'h00) chen = 8'h81;
      diff = lfsr[15:8];
      tch = lfsr[18:16];
      temp_on = s[0];
      slow <= s[1];
      apb(1'b1, OFS_CHEN, {24'h0, chen});
      apb(1'b1, OFS_CHDIFF, {24'h0, diff});
      apb(1'b1, OFS_SAMPLE, s + 1);
      apb(1'b1, OFS_CTRL, 32'h1 | (temp_on << 5) | (tch << 9));
      scan_sync();
      wait_done();
      for (int c = 0; c < 8; c++) if (chen[c]) begin
        apb(1'b0, OFS_RES0 + 8'(c * 4), 32'h0);
        chk(rd, {20'h0, mres[c]});
      end
      fifo_drain($countones(chen));
      apb(1'b1, OFS_STATUS, 32'h3);
    end
    chk(fe_lp_clk_sel, 1'b0);
    // range limits flag a single result before the scan ends
    temp_on = 1'b0;
    chen = 8'hF0;
    slow <= 1'b1;
    apb(1'b1, OFS_CHEN, 32'hF0);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFS_LIMLO, m ? 32'hFFF : 32'h0);
      apb(1'b1, OFS_LIMHI, m ? 32'hFFF : 32'h0);
      apb(1'b1, OFS_CTRL, m ? 32'h81 : 32'h101);
      scan_sync();
      n = 0;
      while (fe_done !== 1'b1 && n < 100) begin @(posedge clk); n++; end
      repeat (3) @(posedge clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[1:0], 2'h2);
      chk(irq, 1'b1);
      wait_done();
      apb(1'b1, OFS_STATUS, 32'h3);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      fifo_drain(4);
    end
    // hibernate holds the sequencer, then free running scans repeat
    chen = 8'h06;
    apb(1'b1, OFS_CHEN, 32'h06);
    hibernate <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h3);
    nconv = 0;
    repeat (40) @(posedge clk);
    chk(nconv, 0);
    hibernate <= 1'b0;
    repeat (150) @(posedge clk);
    chk(nconv, 4);
    apb(1'b1, OFS_CTRL, 32'h0);
    repeat (20) @(posedge clk);
    fifo_drain(4);
    summarize();
  end
endmodule // sar_adc_scan_sequencer_tb_top
`default_nettype wire
